// File: common/eprom_prog_defines.svh
`ifndef EPROM_PROG_DEFINES_SVH
`define EPROM_PROG_DEFINES_SVH

// Clock and timing figures
`define CLK_PERIOD_NS 5
`define T_PULSE_LONG_US 10000
`define T_PULSE_SHORT_US 500
`define T_SETUP_US 1
`define T_ACCESS_NS 250
`define MAX_PULSES 20
// Cycle counts derived from the figures
`define PULSE_LONG_CYC ((`T_PULSE_LONG_US * 1000) / `CLK_PERIOD_NS)
`define PULSE_SHORT_CYC ((`T_PULSE_SHORT_US * 1000) / `CLK_PERIOD_NS)
`define SETUP_CYC (((`T_SETUP_US * 1000) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ACCESS_CYC ((`T_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Identification byte addresses
`define ID_ADDR_MAKER 1'b0
`define ID_ADDR_DEVICE 1'b1
// Erased cell value
`define ERASED_BYTE 8'hFF

`endif

// File: common/eprom_prog_pkg.sv
package eprom_prog_pkg;

    typedef enum logic [1:0] {
        OP_READ = 2'b00,
        OP_PROG_SINGLE = 2'b01,
        OP_PROG_INTERACTIVE = 2'b10,
        OP_READ_ID = 2'b11
    } op_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETUP = 3'b001,
        ST_PULSE = 3'b010,
        ST_RECOVER = 3'b011,
        ST_VERIFY = 3'b100,
        ST_DONE = 3'b101
    } state_t;

    // Pins driven toward the memory
    typedef struct packed {
        logic [16:0] addr;
        logic id_enable_address_line;
        logic chip_select_n;
        logic output_gate_n;
        logic write_pulse_n;
        logic high_voltage_supply;
        logic [7:0] data_out;
        logic data_oe;
    } pins_t;

    // Whole controller state
    typedef struct packed {
        state_t state;
        op_t op;
        logic [16:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic [21:0] cnt;
        logic [4:0] pulses;
        logic busy;
        logic done;
        logic fail;
        pins_t pins;
    } ctl_t;

endpackage

// File: rtl/eprom_prog_ctrl.sv
`timescale 1ns/1ps
`include "eprom_prog_defines.svh"

// Summary of operation
// - Program needs high supply, gate high
// - Write byte driven on data pins
// - Pulse write line after setup stable
// - Each location gets its own pulse
// - Single mode uses one 10 ms pulse
// - Interactive: 0.5 ms pulses, max 20
// - Write pulse always bounded, never steady
// - Paralleled parts share one pulse
// - Deselected part ignores write pulses
// - Verify reads back under high supply
// - Supply normal outside program and verify
// - Select from decode, gate from strobe
// - Id read: raised line, others low
// - Lowest address picks maker or device
// - Data only with select and gate low
module eprom_prog_ctrl #(
    parameter int PULSE_LONG_CYC = `PULSE_LONG_CYC,
    parameter int PULSE_SHORT_CYC = `PULSE_SHORT_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // User command port
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire eprom_prog_pkg::op_t cmd_op,
    input wire logic [16:0] cmd_addr,
    input wire logic [7:0] cmd_wdata,
    output logic rsp_valid,
    output logic [7:0] rsp_rdata,
    output logic rsp_fail,
    // Memory pins
    output eprom_prog_pkg::pins_t pins,
    input wire logic [7:0] data_pins_in
);

    eprom_prog_pkg::ctl_t ctl_reg;
    eprom_prog_pkg::ctl_t ctl_next;
    logic [7:0] data_meta_reg;
    logic [7:0] data_sync_reg;

    // Two-stage synchroniser on the data pins
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            data_meta_reg <= 8'h00;
            data_sync_reg <= 8'h00;
        end else begin
            data_meta_reg <= data_pins_in;
            data_sync_reg <= data_meta_reg;
        end
    end

    // Idle pin levels: normal supply, deselected, outputs released
    function automatic eprom_prog_pkg::pins_t idle_pins();
        eprom_prog_pkg::pins_t p;
        p = '0;
        p.chip_select_n = 1'b1;
        p.output_gate_n = 1'b1;
        p.write_pulse_n = 1'b1;
        return p;
    endfunction

    // Program is done once every zero bit wanted reads back as zero
    function automatic logic byte_ok(input logic [7:0] want, input logic [7:0] got);
        return (got & ~want) == 8'h00;
    endfunction

    // Next-state logic
    always_comb begin
        ctl_next = ctl_reg;
        ctl_next.done = 1'b0;
        unique case (ctl_reg.state)
            eprom_prog_pkg::ST_IDLE: begin
                ctl_next.pins = idle_pins();
                if (cmd_valid) begin
                    ctl_next.op = cmd_op;
                    ctl_next.addr = cmd_addr;
                    ctl_next.wdata = cmd_wdata;
                    ctl_next.pulses = 5'd0;
                    ctl_next.cnt = 22'(`SETUP_CYC);
                    ctl_next.fail = 1'b0;
                    ctl_next.busy = 1'b1;
                    ctl_next.state = eprom_prog_pkg::ST_SETUP;
                    ctl_next.pins.chip_select_n = 1'b0;
                    ctl_next.pins.addr = cmd_addr;
                    if (cmd_op == eprom_prog_pkg::OP_READ_ID) begin
                        ctl_next.pins.addr = 17'h0_0000;
                        ctl_next.pins.addr[0] = cmd_addr[0];
                        ctl_next.pins.id_enable_address_line = 1'b1;
                        ctl_next.pins.write_pulse_n = 1'b0;
                    end
                    if (cmd_op == eprom_prog_pkg::OP_PROG_SINGLE || cmd_op == eprom_prog_pkg::OP_PROG_INTERACTIVE) begin
                        ctl_next.pins.high_voltage_supply = 1'b1;
                        ctl_next.pins.data_out = cmd_wdata;
                        ctl_next.pins.data_oe = 1'b1;
                    end else begin
                        ctl_next.pins.output_gate_n = 1'b0;
                    end
                end
            end
            eprom_prog_pkg::ST_SETUP: begin
                ctl_next.cnt = ctl_reg.cnt - 22'd1;
                if (ctl_reg.cnt == 22'd1) begin
                    if (ctl_reg.op == eprom_prog_pkg::OP_PROG_SINGLE) begin
                        ctl_next.cnt = 22'(PULSE_LONG_CYC);
                        ctl_next.pins.write_pulse_n = 1'b0;
                        ctl_next.state = eprom_prog_pkg::ST_PULSE;
                    end else if (ctl_reg.op == eprom_prog_pkg::OP_PROG_INTERACTIVE) begin
                        ctl_next.cnt = 22'(PULSE_SHORT_CYC);
                        ctl_next.pins.write_pulse_n = 1'b0;
                        ctl_next.pulses = ctl_reg.pulses + 5'd1;
                        ctl_next.state = eprom_prog_pkg::ST_PULSE;
                    end else begin
                        ctl_next.cnt = 22'(`ACCESS_CYC + 2);
                        ctl_next.state = eprom_prog_pkg::ST_VERIFY;
                    end
                end
            end
            eprom_prog_pkg::ST_PULSE: begin
                ctl_next.cnt = ctl_reg.cnt - 22'd1;
                if (ctl_reg.cnt == 22'd1) begin
                    ctl_next.pins.write_pulse_n = 1'b1;
                    ctl_next.cnt = 22'(`SETUP_CYC);
                    ctl_next.state = eprom_prog_pkg::ST_RECOVER;
                end
            end
            eprom_prog_pkg::ST_RECOVER: begin
                // Data hold, then release bus and read back
                ctl_next.cnt = ctl_reg.cnt - 22'd1;
                if (ctl_reg.cnt == 22'd1) begin
                    ctl_next.pins.data_oe = 1'b0;
                    ctl_next.pins.output_gate_n = 1'b0;
                    ctl_next.cnt = 22'(`ACCESS_CYC + 2);
                    ctl_next.state = eprom_prog_pkg::ST_VERIFY;
                end
            end
            eprom_prog_pkg::ST_VERIFY: begin
                ctl_next.cnt = ctl_reg.cnt - 22'd1;
                if (ctl_reg.cnt == 22'd1) begin
                    ctl_next.rdata = data_sync_reg;
                    ctl_next.pins.output_gate_n = 1'b1;
                    if (ctl_reg.op == eprom_prog_pkg::OP_READ_ID) begin
                        // Drop the raised line together with the control pins
                        ctl_next.pins = idle_pins();
                    end
                    if (ctl_reg.op == eprom_prog_pkg::OP_PROG_INTERACTIVE && !byte_ok(ctl_reg.wdata, data_sync_reg)
                        && ctl_reg.pulses < 5'(`MAX_PULSES)) begin
                        ctl_next.pins.data_oe = 1'b1;
                        ctl_next.cnt = 22'(`SETUP_CYC);
                        ctl_next.state = eprom_prog_pkg::ST_SETUP;
                    end else begin
                        ctl_next.fail = (ctl_reg.op == eprom_prog_pkg::OP_PROG_SINGLE
                            || ctl_reg.op == eprom_prog_pkg::OP_PROG_INTERACTIVE)
                            && !byte_ok(ctl_reg.wdata, data_sync_reg);
                        ctl_next.state = eprom_prog_pkg::ST_DONE;
                    end
                end
            end
            eprom_prog_pkg::ST_DONE: begin
                ctl_next.pins = idle_pins();
                ctl_next.done = 1'b1;
                ctl_next.busy = 1'b0;
                ctl_next.state = eprom_prog_pkg::ST_IDLE;
            end
            default: begin
                ctl_next.pins = idle_pins();
                ctl_next.busy = 1'b0;
                ctl_next.state = eprom_prog_pkg::ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctl_reg <= '0;
            ctl_reg.pins.chip_select_n <= 1'b1;
            ctl_reg.pins.output_gate_n <= 1'b1;
            ctl_reg.pins.write_pulse_n <= 1'b1;
        end else begin
            ctl_reg <= ctl_next;
        end
    end

    // Outputs
    assign cmd_ready = ctl_reg.state == eprom_prog_pkg::ST_IDLE;
    assign rsp_valid = ctl_reg.done;
    assign rsp_rdata = ctl_reg.rdata;
    assign rsp_fail = ctl_reg.fail;
    assign pins = ctl_reg.pins;

    // pulse only under high supply, gate high
    property p_pulse_mode;
        @(posedge clk) disable iff (!arst_n)
        !pins.write_pulse_n && !pins.id_enable_address_line |-> pins.high_voltage_supply && pins.output_gate_n
            && !pins.chip_select_n;
    endproperty
    a_pulse_mode: assert property (p_pulse_mode) else $error("pulse outside program mode");

    property p_data_driven;
        @(posedge clk) disable iff (!arst_n)
        !pins.write_pulse_n && !pins.id_enable_address_line |-> pins.data_oe && pins.data_out == ctl_reg.wdata;
    endproperty
    a_data_driven: assert property (p_data_driven) else $error("data not driven in pulse");

    property p_setup_before;
        @(posedge clk) disable iff (!arst_n)
        $fell(pins.write_pulse_n) && !pins.id_enable_address_line |-> $past(pins.data_oe) && $stable(pins.addr);
    endproperty
    a_setup_before: assert property (p_setup_before) else $error("pulse without setup");

    // no more than the pulse limit
    property p_pulse_limit;
        @(posedge clk) disable iff (!arst_n)
        ctl_reg.pulses <= 5'(`MAX_PULSES);
    endproperty
    a_pulse_limit: assert property (p_pulse_limit) else $error("too many pulses");

    property p_pulse_bounded;
        @(posedge clk) disable iff (!arst_n)
        !pins.write_pulse_n && !pins.id_enable_address_line |-> ctl_reg.state == eprom_prog_pkg::ST_PULSE
            && ctl_reg.cnt != 22'd0 && ctl_reg.cnt <= 22'(PULSE_LONG_CYC);
    endproperty
    a_pulse_bounded: assert property (p_pulse_bounded) else $error("pulse unbounded");

    property p_supply_idle;
        @(posedge clk) disable iff (!arst_n)
        cmd_ready |-> !pins.high_voltage_supply;
    endproperty
    a_supply_idle: assert property (p_supply_idle) else $error("high supply while idle");

    // id line only with control pins low
    property p_id_access;
        @(posedge clk) disable iff (!arst_n)
        pins.id_enable_address_line |-> pins.addr[16:1] == 16'h0000 && !pins.high_voltage_supply
            && !pins.write_pulse_n && !pins.chip_select_n && !pins.output_gate_n;
    endproperty
    a_id_access: assert property (p_id_access) else $error("bad id access levels");

    property p_no_contention;
        @(posedge clk) disable iff (!arst_n)
        !pins.output_gate_n |-> !pins.data_oe && !pins.chip_select_n;
    endproperty
    a_no_contention: assert property (p_no_contention) else $error("bus contention");

    // answer follows done state in one cycle
    property p_answer;
        @(posedge clk) disable iff (!arst_n)
        ctl_reg.state == eprom_prog_pkg::ST_DONE |=> rsp_valid && cmd_ready;
    endproperty
    a_answer: assert property (p_answer) else $error("answer missing");

endmodule

// File: verif/eprom_model.sv
`timescale 1ns/1ps
module eprom_model #(
    parameter logic [7:0] MAKER_CODE = 8'h5A, // Arbitrary value
    parameter logic [7:0] DEVICE_CODE = 8'hC3 // Arbitrary value
) (
    // Controller pins
    input wire eprom_prog_pkg::pins_t pins,
    input wire logic [4:0] pulses_needed,
    // Resolved data wire
    output logic [7:0] bus
);
    logic [7:0] mem [0:131071];
    logic [7:0] last;
    logic [7:0] val;
    logic drive;
    int cnt;
    initial begin
        foreach (mem[i]) mem[i] = 8'hFF;
        last = 8'h00;
        cnt = 0;
    end
    assign val = pins.id_enable_address_line ? (pins.addr[0] ? DEVICE_CODE : MAKER_CODE) : mem[pins.addr];
    assign drive = !pins.chip_select_n && !pins.output_gate_n;
    // Released wire shows the inverse of the last driven byte
    assign bus = pins.data_oe ? pins.data_out : (drive ? val : ~last);
    always @(val or drive) begin
        if (drive) begin
            last = val;
        end
    end
    always @(posedge pins.write_pulse_n) begin
        if (!pins.chip_select_n && pins.output_gate_n && pins.high_voltage_supply) begin
            cnt = cnt + 1;
            if (cnt >= pulses_needed) begin
                mem[pins.addr] = mem[pins.addr] & bus;
            end
        end
    end
    // Stubborn cells count pulses per programming session
    always @(negedge pins.high_voltage_supply) begin
        cnt = 0;
    end
endmodule

// File: verif/tb.sv
`timescale 1ns/1ps
module tb;
    localparam int L = 20;
    localparam int S = 5;
    localparam logic [7:0] MAKER = 8'h5A; // Arbitrary value
    localparam logic [7:0] DEVICE = 8'hC3; // Arbitrary value
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic cmd_valid = 1'b0;
    logic cmd_ready;
    eprom_prog_pkg::op_t cmd_op = eprom_prog_pkg::OP_READ;
    logic [16:0] cmd_addr = 17'h0_0000;
    logic [7:0] cmd_wdata = 8'h00;
    logic rsp_valid;
    logic [7:0] rsp_rdata;
    logic rsp_fail;
    eprom_prog_pkg::pins_t pins;
    logic [7:0] bus;
    logic [4:0] need = 5'h01;
    logic [31:0] lfsr = 32'h0000_a8cf;
    int n_fail = 0;
    int checks_done = 0;
    int ref_mem [int];
    int npulse = 0;
    int wmin = 0;
    int wmax = 0;
    int lowcnt = 0;
    int bad = 0;

    always #2.5 clk = ~clk;

    eprom_prog_ctrl #(.PULSE_LONG_CYC(L), .PULSE_SHORT_CYC(S)) u_eprom_prog_ctrl (
        .clk(clk), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .rsp_fail(rsp_fail), .pins(pins), .data_pins_in(bus));
    eprom_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE)) u_eprom_model (
        .pins(pins), .pulses_needed(need), .bus(bus));

    // Pulse widths and counts, and pin states that must never occur
    always @(negedge clk) begin
        if (pins.write_pulse_n === 1'b0 && pins.id_enable_address_line !== 1'b1) begin
            lowcnt = lowcnt + 1;
            if (pins.output_gate_n !== 1'b1 || pins.high_voltage_supply !== 1'b1 || pins.data_oe !== 1'b1) begin
                bad = bad | 1;
            end
        end else if (lowcnt != 0) begin
            npulse = npulse + 1;
            if (lowcnt < wmin) wmin = lowcnt;
            if (lowcnt > wmax) wmax = lowcnt;
            lowcnt = 0;
        end
        if (cmd_ready === 1'b1 && pins.high_voltage_supply !== 1'b0) bad = bad | 2;
        if (pins.id_enable_address_line === 1'b1 && (pins.addr[16:1] !== 16'h0000 || pins.chip_select_n !== 1'b0
            || pins.output_gate_n !== 1'b0 || pins.write_pulse_n !== 1'b0 || pins.high_voltage_supply !== 1'b0)) begin
            bad = bad | 4;
        end
    end

    task automatic check(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("MISMATCH t=%0t %s", $time, msg);
        end
    endtask

    task automatic finish_test();
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // One command from a falling edge, checked against the reference
    task automatic run(input eprom_prog_pkg::op_t op, input logic [16:0] a, input logic [7:0] wd,
                       input logic [4:0] nd);
        int np, nv, mx, k, prog, ef;
        prog = (op == eprom_prog_pkg::OP_PROG_SINGLE || op == eprom_prog_pkg::OP_PROG_INTERACTIVE);
        nv = ref_mem.exists(int'(a)) ? ref_mem[int'(a)] : 255;
        mx = (op == eprom_prog_pkg::OP_PROG_SINGLE) ? 1 : 20;
        np = 0;
        for (int p = 1; prog && p <= mx; p++) begin
            np = p;
            if (p >= nd) nv = nv & int'(wd);
            if ((~int'(wd) & nv & 255) == 0) break;
        end
        ef = prog && ((~int'(wd) & nv & 255) != 0);
        if (op == eprom_prog_pkg::OP_READ_ID) nv = a[0] ? DEVICE : MAKER;
        need = nd;
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_addr = a;
        cmd_wdata = wd;
        k = 0;
        while (cmd_ready !== 1'b1 && k < 10) begin
            @(negedge clk);
            k++;
        end
        check(k < 10, "not ready");
        @(negedge clk);
        // Taken at the edge just passed: release the request at once
        cmd_valid = 1'b0;
        npulse = 0;
        wmin = 1000;
        wmax = 0;
        bad = 0;
        cmd_addr = ~a;
        k = 0;
        while (rsp_valid !== 1'b1 && k < 20000) begin
            @(negedge clk);
            k++;
        end
        check(k < 20000, "no response");
        if (prog) begin
            ref_mem[int'(a)] = nv;
            check(wmin == (mx == 1 ? L : S) && wmax == wmin, "pulse width");
            check(rsp_fail === ef[0], "fail flag");
        end
        check(npulse == np, "pulse count");
        check(rsp_rdata === nv[7:0], "read data");
        check(bad == 0, "pin state");
    endtask

    initial begin
        repeat (16) @(negedge clk);
        arst_n = 1'b1;
        check(cmd_ready === 1'b1 && pins.chip_select_n === 1'b1 && pins.write_pulse_n === 1'b1, "reset pins");
        run(eprom_prog_pkg::OP_READ, 17'h1_2345, 8'h00, 5'h01);
        run(eprom_prog_pkg::OP_READ_ID, 17'h1_5554, 8'h00, 5'h01);
        run(eprom_prog_pkg::OP_READ_ID, 17'h0_AAAB, 8'h00, 5'h01);
        run(eprom_prog_pkg::OP_PROG_SINGLE, 17'h0_0010, 8'h0F, 5'h01);
        run(eprom_prog_pkg::OP_PROG_INTERACTIVE, 17'h0_0010, 8'hF0, 5'h03);
        run(eprom_prog_pkg::OP_PROG_INTERACTIVE, 17'h1_0020, 8'h55, 5'h19);
        run(eprom_prog_pkg::OP_PROG_SINGLE, 17'h0_0030, 8'hA5, 5'h02);
        run(eprom_prog_pkg::OP_PROG_INTERACTIVE, 17'h0_0040, 8'hFF, 5'h05);
        run(eprom_prog_pkg::OP_READ, 17'h0_0010, 8'h00, 5'h01);
        for (int i = 0; i < 16; i++) begin
            lfsr = lfsr_next(lfsr);
            run(eprom_prog_pkg::op_t'(lfsr[1:0]), lfsr[24:8] & 17'h1_0003, lfsr[31:24],
                5'(lfsr[5:4] % 3 + 1));
        end
        finish_test();
    end

    // Watchdog well beyond the expected run length
    initial begin
        #300000;
        check(1'b0, "timeout");
        finish_test();
    end
endmodule
